// *** dv/aag_agc_model.sv ***
// far side: outside gain-control logic reading the alarm pins
// it drives the oscillator-select level on every pin the block releases
module aag_agc_model
(
   input wire logic clk_i,
   input wire logic [3:0] pin_o_i,
   input wire logic [3:0] pin_oe_b_i,
   input wire logic [3:0] osc_lvl_i,
   output logic [3:0] pin_i_o,
   output logic [3:0] alarm_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // the wire shows the block's value where it drives, our level elsewhere
   assign pin_i_o = (~pin_oe_b_i & pin_o_i) | (pin_oe_b_i & osc_lvl_i);
   always_ff @(posedge clk_i)
   begin
      alarm_o <= pin_o_i & ~pin_oe_b_i;
   end
endmodule

// *** dv/aag_props.sv ***
// checker for the alarm routing block: bus answer, pin drive, reset state
// sees only the top module's ports; bound at the foot of this file
module aag_props
(
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic [3:0] PIN_I,
   input wire logic [3:0] PIN_O,
   input wire logic [3:0] PIN_OE_B_O,
   input wire logic [3:0] OSC_SEL_PIN_O,
   input wire logic AGC_RST_O,
   input wire logic IRQ_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_B_I);
   logic wr_ack;
   assign wr_ack = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
   a_ack_on_take: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("no answer one cycle after a request");
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("answer stands longer than one cycle");
   a_reset_quiet: assert property ($rose(RST_B_I) |->
      PIN_OE_B_O == 4'hf && PIN_O == 4'h0 && !WB_ACK_O && !IRQ_O && !AGC_RST_O)
      else $error("outputs not at rest after reset");
   a_released_low: assert property ((PIN_O & PIN_OE_B_O) == 4'h0)
      else $error("released pin carries a high value");
   a_osc_copy: assert property ($past(RST_B_I) |->
      OSC_SEL_PIN_O == ($past(PIN_I) & PIN_OE_B_O))
      else $error("oscillator select does not follow input pins");
   a_agc_follow: assert property (wr_ack && WB_ADR_I[9:2] == aag_pkg::IDX_AGC_RST |=>
      AGC_RST_O == $past(WB_DAT_I[4]))
      else $error("gain-control reset does not follow its bit");
   a_dir_follow: assert property (wr_ack && WB_ADR_I[9:2] == aag_pkg::IDX_PIN_DIR |=>
      PIN_OE_B_O == ~$past(WB_DAT_I[3:0]))
      else $error("pin enables do not follow direction bits");
   a_read_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
      else $error("read data has bits above the byte");
   c_write: cover property (wr_ack);
   c_irq: cover property ($rose(IRQ_O));
   c_drive: cover property (PIN_OE_B_O != 4'hf && PIN_O != 4'h0);
endmodule

bind aag_top aag_props aag_props_inst
(
   .CLK_SYS_I, .RST_B_I, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I,
   .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .PIN_I, .PIN_O, .PIN_OE_B_O, .OSC_SEL_PIN_O,
   .AGC_RST_O, .IRQ_O
);

// *** dv/tb_top.sv ***
// self-checking bench for the alarm routing block and its register page
// drives bus, flags and power; the far side model resolves the pins
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [15:0] pwr_a = 16'h0;
   logic [15:0] pwr_b = 16'h0;
   logic [3:0] osc = 4'h0;
   aag_pkg::aag_flags_t fl_a = '0;
   aag_pkg::aag_flags_t fl_b = '0;
   logic [31:0] rdat;
   logic [3:0] pin_i, pin_o, oe_b, osc_sel, alarm;
   logic ack, agc_rst, irq;
   int fail_count = 0;
   int n_checks = 0;
   always #20 clk = ~clk;
   aag_top aag_top_inst
   (
      .CLK_SYS_I(clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .CHA_POWER_I(pwr_a), .CHB_POWER_I(pwr_b), .CHA_FLAGS_I(fl_a), .CHB_FLAGS_I(fl_b),
      .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_B_O(oe_b), .OSC_SEL_PIN_O(osc_sel),
      .AGC_RST_O(agc_rst), .IRQ_O(irq)
   );
   aag_agc_model aag_agc_model_inst
   (
      .clk_i(clk), .pin_o_i(pin_o), .pin_oe_b_i(oe_b), .osc_lvl_i(osc),
      .pin_i_o(pin_i), .alarm_o(alarm)
   );
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // entered just after an edge; the watchdog ends a missing answer
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] r);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      chk(r, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic t_reset;
      logic [7:0] ix [15] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h27, 8'h2b,
                              8'h32, 8'h33, 8'h34, 8'h35, 8'h37, 8'h40, 8'h41};
      chk(32'(oe_b), 32'hf);
      for (int i = 0; i < 15; i++)
         rd(ix[i], 32'h0);
   endtask
   // all ones into each place; only the documented bits may stick
   task automatic t_regs;
      logic [7:0] ix [5] = '{8'h27, 8'h2b, 8'h37, 8'h23, 8'h3f};
      logic [7:0] ex [5] = '{8'h01, 8'h10, 8'h0f, 8'hff, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         wr(ix[i], 8'hff);
         rd(ix[i], {24'h0, ex[i]});
         wr(ix[i], 8'h00);
      end
   endtask
   // phase 0: only the chosen bit high; phase 1: all but it high
   task automatic t_route;
      int k, p;
      logic [8:0] oh;
      wr(8'h37, 8'h0f);
      for (int c = 0; c < 19; c++)
      begin
         k = c % 9;
         p = c % 4;
         oh = 9'h100 >> k;
         wr(8'(8'h32 + p), c[7:0]);
         for (int ph = 0; ph < 2; ph++)
         begin
            fl_a <= (c < 9) ? (ph ? ~oh : oh) : (ph ? 9'h1ff : 9'h000);
            fl_b <= (c < 9) ? (ph ? 9'h1ff : 9'h000) : (ph ? ~oh : oh);
            idle(3);
            chk(32'(pin_o[p]), 32'(ph == 0 && c < 18 && k != 6 && k != 7));
         end
      end
   endtask
   task automatic t_pins;
      osc <= 4'ha;
      wr(8'h37, 8'h05);
      idle(3);
      chk(32'(oe_b), 32'ha);
      chk(32'(osc_sel), 32'ha);
      chk(32'(pin_o), 32'h0);
      chk(32'(alarm), 32'h0);
      osc <= 4'h0;
      fl_a <= '0;
      fl_b <= '0;
   endtask
   task automatic chk_rms(input logic [15:0] pa, input logic [2:0] exp);
      pwr_a <= pa;
      pwr_b <= pa;
      idle(120);
      chk(32'(pin_o[2:0]), 32'(exp));
   endtask
   task automatic t_rms;
      logic [31:0] r;
      wr(8'h22, 8'h31);
      wr(8'h23, 8'h0a);
      wr(8'h25, 8'h01);
      wr(8'h21, 8'h02);
      wr(8'h32, 8'h06);
      wr(8'h33, 8'h07);
      wr(8'h34, 8'h0f);
      wr(8'h37, 8'h07);
      wr(8'h20, 8'h01);
      wr(8'h2b, 8'h10);
      chk(32'(agc_rst), 32'h1);
      wr(8'h2b, 8'h00);
      chk_rms(16'h0a32, 3'h5);
      wr(8'h27, 8'h01);
      chk_rms(16'h0a32, 3'h7);
      chk_rms(16'h0a31, 3'h0);
      chk_rms(16'h00ff, 3'h5);
      bus(1'b0, 8'h40, 8'h00, r);
      chk(r, 32'h7);
      chk(32'(irq), 32'h0);
      wr(8'h41, 8'h04);
      idle(2);
      chk(32'(irq), 32'h1);
      wr(8'h2b, 8'h10);
      chk_rms(16'h00ff, 3'h0);
      wr(8'h2b, 8'h00);
      wr(8'h20, 8'h00);
      chk_rms(16'h00ff, 3'h0);
      wr(8'h40, 8'h07);
      idle(2);
      chk(32'(irq), 32'h0);
      rd(8'h40, 32'h0);
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_regs();
      t_route();
      t_pins();
      t_rms();
      test_done();
   end
   initial
   begin
      #800000;
      fail_count++;
      test_done();
   end
endmodule

// *** src/aag_pkg.sv ***
// package for the gain-control alarm routing block: register map, fields, resets, carriers
// assumes a classic wishbone slave with 32-bit data, one register per aligned word
package aag_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PWR_HI_LOW = 8'h22;
   localparam logic [7:0] IDX_PWR_HI_UPP = 8'h23;
   localparam logic [7:0] IDX_PWR_LO_LOW = 8'h24;
   localparam logic [7:0] IDX_PWR_LO_UPP = 8'h25;
   localparam logic [7:0] IDX_DET_ENABLE = 8'h20;
   localparam logic [7:0] IDX_BLK_LEN = 8'h21;
   localparam logic [7:0] IDX_RMS_FMT = 8'h27;
   localparam logic [7:0] IDX_AGC_RST = 8'h2b;
   localparam logic [7:0] IDX_PIN1_SEL = 8'h32;
   localparam logic [7:0] IDX_PIN2_SEL = 8'h33;
   localparam logic [7:0] IDX_PIN3_SEL = 8'h34;
   localparam logic [7:0] IDX_PIN4_SEL = 8'h35;
   localparam logic [7:0] IDX_PIN_DIR = 8'h37;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h40;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
   localparam logic [7:0] IDX_DET_STAT = 8'h42;
   // field positions
   localparam int BIT_DET_EN = 0;
   localparam int BIT_RMS_FMT = 0;
   localparam int BIT_AGC_RST = 4;
   localparam int BLK_LEN_W = 5;
   localparam logic [4:0] BLK_LEN_MAX = 5'h10;
   localparam int DIR_W = 4;
   localparam logic [7:0] SEL_LAST = 8'h11;
   localparam logic [7:0] SEL_PER_CH = 8'h09;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_THR = 16'h0000;
   // sample clock divided by 8 is one enable pulse every eight system clocks; the divider counts from 0 up to this value
   localparam logic [2:0] SAMPLE_DIV = 3'h7;
   // irq status bits
   localparam int IRQ_HIGH = 0;
   localparam int IRQ_LOW = 1;
   localparam int IRQ_BLOCK = 2;
   localparam int IRQ_W = 3;

   typedef struct packed
   {
      logic first_pk_0;
      logic first_pk_1;
      logic second_pk_0;
      logic second_pk_1;
      logic blk_high;
      logic blk_low;
      logic rms_0;
      logic rms_1;
      logic fast_ovr;
   } aag_flags_t;

   typedef struct packed
   {
      logic [15:0] high;
      logic [15:0] low;
   } aag_thr_t;
endpackage

// *** src/aag_rms_det.sv ***
// rms power detector: averages squared samples over 2^m enable ticks and compares
// assumes one squared sample per tick (unsigned, full scale = 2^16 per lsb scaling)
module aag_rms_det
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic tick_i,
   input wire logic [4:0] exp_i,
   input wire logic [15:0] power_i,
   input wire aag_pkg::aag_thr_t thr_i,
   input wire logic two_bit_i,
   output logic [1:0] flag_o,
   output logic done_o
);
   logic [32:0] acc_q, acc_d;
   logic [16:0] cnt_q, cnt_d;
   logic [1:0] flag_q, flag_d;
   logic done_q, done_d;
   logic [15:0] avg;
   logic [16:0] len;
   logic [32:0] sum;

   always_comb
   begin
      len = 17'h00001 << exp_i;
      // the block's last sample is summed in before the mean is taken
      sum = acc_q + 33'(power_i);
      avg = 16'(sum >> exp_i);
      acc_d = acc_q;
      cnt_d = cnt_q;
      flag_d = flag_q;
      done_d = 1'b0;
      if (!enable_i)
      begin
         // disabled detector holds flags clear and restarts the block
         acc_d = '0;
         cnt_d = '0;
         flag_d = 2'b00; // see R12
      end
      else if (tick_i)
      begin
         acc_d = sum;
         if (cnt_q + 17'h00001 >= len) // see R13
         begin
            cnt_d = '0;
            done_d = 1'b1;
            // thresholds are squared amplitude times 65536, same scale as power_i
            if (two_bit_i) // see R3
            begin
               flag_d[0] = (avg > thr_i.high) || (avg < thr_i.low); // see R1
               flag_d[1] = (avg > thr_i.high); // see R2
            end
            else
            begin
               flag_d[0] = (avg > thr_i.high);
               flag_d[1] = 1'b0;
            end
            acc_d = '0;
         end
         else
         begin
            cnt_d = cnt_q + 17'h00001;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         acc_q <= '0;
         cnt_q <= '0;
         flag_q <= 2'b00;
         done_q <= 1'b0;
      end
      else
      begin
         acc_q <= acc_d;
         cnt_q <= cnt_d;
         flag_q <= flag_d;
         done_q <= done_d;
      end
   end

   assign flag_o = flag_q;
   assign done_o = done_q;
endmodule

// *** src/aag_top.sv ***
// register bank and alarm pin routing for the power detector page
// assumes a classic wishbone master, inputs synchronous to CLK_SYS_I
// Notes on behaviour
// R1: average power is compared with a 16-bit high and a 16-bit low threshold to make rms flags.
// R2: a threshold lsb is one part in 65536 of full-scale squared amplitude.
// R3: rms flags are 1-bit when the format bit is 0 and 2-bit when it is 1.
// R4: the gain-control module is held in reset while bit 4 of its reset register is 1.
// R5: software writes 10h then 00h to the gain-control reset register before operation.
// R6: codes 0 to 3 route the bits of the two filtered peak flags of channel a.
// R7: codes 4, 5 and 8 route block peak high, block peak low and fast overrange of channel a.
// R8: codes 6 and 7 route rms power flag bits 0 and 1 of channel a.
// R9: codes 9 to 17 route the same nine signals from channel b.
// R10: direction bits 0 to 3 make pins one to four inputs when 0 and outputs when 1.
// R11: after reset all threshold, format, reset, select and direction fields are zero.
// R12: the rms detector runs only while its enable bit is 1.
// R13: the averaging block is 2^m ticks of the sample clock over 8, m from 0 to 16.
// R14: software writes zeros to reserved bits; the device ignores them.
// R15: input pins are not driven and select codes above 17 drive the pin low.
//
// Our own choice: the Wishbone register port.
module aag_top
(
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [15:0] CHA_POWER_I,
   input wire logic [15:0] CHB_POWER_I,
   input wire aag_pkg::aag_flags_t CHA_FLAGS_I,
   input wire aag_pkg::aag_flags_t CHB_FLAGS_I,
   input wire logic [3:0] PIN_I,
   output logic [3:0] PIN_O,
   output logic [3:0] PIN_OE_B_O,
   output logic [3:0] OSC_SEL_PIN_O,
   output logic AGC_RST_O,
   output logic IRQ_O
);
   typedef logic [7:0] aag_sel_t;

   logic det_en_q, det_en_d;
   logic [4:0] blk_q, blk_d;
   aag_pkg::aag_thr_t thr_q, thr_d;
   logic fmt_q, fmt_d;
   logic agc_rst_q, agc_rst_d;
   aag_sel_t sel_q [4], sel_d [4];
   logic [3:0] dir_q, dir_d;
   logic [2:0] irq_stat_q, irq_stat_d;
   logic [2:0] irq_mask_q, irq_mask_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   logic [2:0] div_q, div_d;
   logic tick_q, tick_d;
   logic [3:0] pin_q, pin_d;
   logic [3:0] oe_b_q, oe_b_d;
   logic [3:0] osc_q, osc_d;
   logic irq_q, irq_d;
   logic [1:0] rms_a, rms_b;
   logic done_a, done_b;
   logic [1:0] rms_a_prev_q;
   logic run_en;
   logic wr;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [2:0] ev;
   aag_pkg::aag_flags_t live_a, live_b;

   // pick one alarm bit from the nine-signal set of a channel
   function automatic logic pick(input aag_pkg::aag_flags_t f, input logic [7:0] c);
      logic r;
      r = 1'b0;
      case (c)
         8'h00: r = f.first_pk_0; // see R6
         8'h01: r = f.first_pk_1;
         8'h02: r = f.second_pk_0;
         8'h03: r = f.second_pk_1;
         8'h04: r = f.blk_high; // see R7
         8'h05: r = f.blk_low;
         8'h06: r = f.rms_0; // see R8
         8'h07: r = f.rms_1;
         8'h08: r = f.fast_ovr;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic route(input aag_pkg::aag_flags_t a, input aag_pkg::aag_flags_t b,
                                  input logic [7:0] c);
      logic r;
      r = 1'b0;
      if (c > aag_pkg::SEL_LAST)
         r = 1'b0; // see R15
      else if (c >= aag_pkg::SEL_PER_CH)
         r = pick(b, c - aag_pkg::SEL_PER_CH); // see R9
      else
         r = pick(a, c);
      return r;
   endfunction

   // detector is held cleared and restarted while the gain-control module sits in reset
   assign run_en = det_en_q && !agc_rst_q; // see R4

   aag_rms_det u_det_a
   (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_B_I),
      .enable_i(run_en),
      .tick_i(tick_q),
      .exp_i(blk_q),
      .power_i(CHA_POWER_I),
      .thr_i(thr_q),
      .two_bit_i(fmt_q),
      .flag_o(rms_a),
      .done_o(done_a)
   );

   aag_rms_det u_det_b
   (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_B_I),
      .enable_i(run_en),
      .tick_i(tick_q),
      .exp_i(blk_q),
      .power_i(CHB_POWER_I),
      .thr_i(thr_q),
      .two_bit_i(fmt_q),
      .flag_o(rms_b),
      .done_o(done_b)
   );

   always_comb
   begin
      live_a = CHA_FLAGS_I;
      live_a.rms_0 = rms_a[0];
      live_a.rms_1 = rms_a[1];
      live_b = CHB_FLAGS_I;
      live_b.rms_0 = rms_b[0];
      live_b.rms_1 = rms_b[1];
   end

   // bus decode: only byte lane 0 carries data, reserved bits are dropped on write
   assign idx = WB_ADR_I[9:2];
   assign wbyte = WB_DAT_I[7:0];
   assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q && WB_SEL_I[0];
   assign ev = {done_a | done_b, rms_a[1] & ~rms_a_prev_q[1], rms_a[0] & ~rms_a_prev_q[0]};

   always_comb
   begin
      det_en_d = det_en_q;
      blk_d = blk_q;
      thr_d = thr_q;
      fmt_d = fmt_q;
      agc_rst_d = agc_rst_q;
      sel_d = sel_q;
      dir_d = dir_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      if (wr)
      begin
         case (idx)
            aag_pkg::IDX_DET_ENABLE: det_en_d = wbyte[aag_pkg::BIT_DET_EN]; // see R12
            aag_pkg::IDX_BLK_LEN:
               // exponents above 16 are clamped, the counter is only 17 bits
               blk_d = (wbyte[4:0] > aag_pkg::BLK_LEN_MAX) ? aag_pkg::BLK_LEN_MAX
                                                          : wbyte[4:0]; // see R13
            aag_pkg::IDX_PWR_HI_LOW: thr_d.high[7:0] = wbyte; // see R1
            aag_pkg::IDX_PWR_HI_UPP: thr_d.high[15:8] = wbyte;
            aag_pkg::IDX_PWR_LO_LOW: thr_d.low[7:0] = wbyte;
            aag_pkg::IDX_PWR_LO_UPP: thr_d.low[15:8] = wbyte;
            aag_pkg::IDX_RMS_FMT: fmt_d = wbyte[aag_pkg::BIT_RMS_FMT]; // see R3
            aag_pkg::IDX_AGC_RST: agc_rst_d = wbyte[aag_pkg::BIT_AGC_RST]; // see R4
            aag_pkg::IDX_PIN1_SEL: sel_d[0] = wbyte;
            aag_pkg::IDX_PIN2_SEL: sel_d[1] = wbyte;
            aag_pkg::IDX_PIN3_SEL: sel_d[2] = wbyte;
            aag_pkg::IDX_PIN4_SEL: sel_d[3] = wbyte;
            aag_pkg::IDX_PIN_DIR: dir_d = wbyte[3:0]; // see R14
            aag_pkg::IDX_IRQ_MASK: irq_mask_d = wbyte[2:0];
            aag_pkg::IDX_IRQ_STAT: irq_stat_d = irq_stat_q & ~wbyte[2:0];
            default: irq_stat_d = irq_stat_q;
         endcase
      end
      // a new event outranks a clear in the same cycle
      irq_stat_d = irq_stat_d | ev;
   end

   always_comb
   begin
      ack_d = WB_CYC_I && WB_STB_I && !ack_q;
      rdat_d = '0;
      if (WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_q)
      begin
         case (idx)
            aag_pkg::IDX_DET_ENABLE: rdat_d[0] = det_en_q;
            aag_pkg::IDX_BLK_LEN: rdat_d[4:0] = blk_q;
            aag_pkg::IDX_PWR_HI_LOW: rdat_d[7:0] = thr_q.high[7:0];
            aag_pkg::IDX_PWR_HI_UPP: rdat_d[7:0] = thr_q.high[15:8];
            aag_pkg::IDX_PWR_LO_LOW: rdat_d[7:0] = thr_q.low[7:0];
            aag_pkg::IDX_PWR_LO_UPP: rdat_d[7:0] = thr_q.low[15:8];
            aag_pkg::IDX_RMS_FMT: rdat_d[0] = fmt_q;
            aag_pkg::IDX_AGC_RST: rdat_d[aag_pkg::BIT_AGC_RST] = agc_rst_q;
            aag_pkg::IDX_PIN1_SEL: rdat_d[7:0] = sel_q[0];
            aag_pkg::IDX_PIN2_SEL: rdat_d[7:0] = sel_q[1];
            aag_pkg::IDX_PIN3_SEL: rdat_d[7:0] = sel_q[2];
            aag_pkg::IDX_PIN4_SEL: rdat_d[7:0] = sel_q[3];
            aag_pkg::IDX_PIN_DIR: rdat_d[3:0] = dir_q;
            aag_pkg::IDX_IRQ_STAT: rdat_d[2:0] = irq_stat_q;
            aag_pkg::IDX_IRQ_MASK: rdat_d[2:0] = irq_mask_q;
            aag_pkg::IDX_DET_STAT: rdat_d[3:0] = {rms_b, rms_a};
            default: rdat_d = '0;
         endcase
      end
   end

   always_comb
   begin
      // divider gives the sample-clock-over-8 tick
      div_d = (div_q == aag_pkg::SAMPLE_DIV) ? 3'h0 : div_q + 3'h1;
      tick_d = (div_q == aag_pkg::SAMPLE_DIV);
      for (int i = 0; i < aag_pkg::DIR_W; i++)
      begin
         pin_d[i] = dir_q[i] ? route(live_a, live_b, sel_q[i]) : 1'b0;
         oe_b_d[i] = !dir_q[i]; // see R10
         // input pins feed oscillator selection; output pins read as zero there
         osc_d[i] = dir_q[i] ? 1'b0 : PIN_I[i]; // see R15
      end
      irq_d = |(irq_stat_q & irq_mask_q);
   end

   // configuration, status and the edge detector behind the status bits
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_B_I)
      begin
         det_en_q <= 1'b0;
         blk_q <= '0;
         thr_q <= {aag_pkg::RST_THR, aag_pkg::RST_THR}; // see R11
         fmt_q <= 1'b0;
         agc_rst_q <= 1'b0;
         for (int i = 0; i < 4; i++)
            sel_q[i] <= aag_pkg::RST_BYTE;
         dir_q <= '0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         rms_a_prev_q <= '0;
      end
      else
      begin
         det_en_q <= det_en_d;
         blk_q <= blk_d;
         thr_q <= thr_d;
         fmt_q <= fmt_d;
         agc_rst_q <= agc_rst_d;
         sel_q <= sel_d;
         dir_q <= dir_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         rms_a_prev_q <= rms_a;
      end
   end

   // bus answer
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_B_I)
      begin
         ack_q <= 1'b0;
         rdat_q <= '0;
      end
      else
      begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // divider and registered pin drive
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_B_I)
      begin
         div_q <= '0;
         tick_q <= 1'b0;
         pin_q <= '0;
         oe_b_q <= 4'hf;
         osc_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         tick_q <= tick_d;
         pin_q <= pin_d;
         oe_b_q <= oe_b_d;
         osc_q <= osc_d;
         irq_q <= irq_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;
   assign PIN_O = pin_q;
   assign PIN_OE_B_O = oe_b_q;
   assign OSC_SEL_PIN_O = osc_q;
   assign AGC_RST_O = agc_rst_q;
   assign IRQ_O = irq_q;
endmodule
